// ### shared/ostd_pkg.sv
// constants, types and helpers for the optical limit detector
// assumes one clock domain; samples arrive from same-clock logic
package ostd_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CODE_W = 20;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h00;
  localparam logic [7:0] IDX_SRC = 8'h50;
  localparam logic [7:0] IDX_HYST = 8'h51;
  localparam logic [7:0] IDX_UP1 = 8'h52;
  localparam logic [7:0] IDX_LO1 = 8'h53;
  localparam logic [7:0] IDX_UP2 = 8'h54;
  localparam logic [7:0] IDX_LO2 = 8'h55;
  localparam logic [7:0] IDX_IRQ_EN = 8'h58;

  // values after reset
  localparam logic [7:0] RST_SRC = 8'h00;
  localparam logic [7:0] RST_HYST = 8'h00;
  localparam logic [7:0] RST_UP = 8'hFF;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;

  // field positions and writable masks
  localparam int unsigned SRC1_LSB = 0;
  localparam int unsigned SRC2_LSB = 4;
  localparam int unsigned LEVEL_LSB = 0;
  localparam int unsigned TIME_LSB = 3;
  localparam int unsigned CHAN1_BIT = 6;
  localparam int unsigned CHAN2_BIT = 7;
  localparam int unsigned FLAG1_BIT = 1;
  localparam int unsigned FLAG2_BIT = 2;
  localparam logic [7:0] SRC_MASK = 8'h77;
  localparam logic [7:0] HYST_MASK = 8'hDF;
  localparam logic [7:0] FLAG_MASK = 8'h06;

  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_RSVD = 3'h7;
  localparam logic [3:0] CNT_MAX = 4'h8;

  typedef enum logic [0:0] {
    OSTD_APB_IDLE = 1'b0,
    OSTD_APB_ACK = 1'b1
  } ostd_apb_state_type;

  // instance on for slot codes 1..6 only
  function automatic logic sel_on(input logic [2:0] s);
    return (s != SEL_OFF) && (s != SEL_RSVD);
  endfunction

  // one limit step is 2048 codes
  function automatic logic [CODE_W:0] limit_code(input logic [7:0] f);
    return {2'b00, f, 11'h000};
  endfunction

  // half of the band magnitude
  function automatic logic [7:0] half_band(input logic [2:0] c);
    if (c == 3'h0) begin
      return 8'h00;
    end
    return 8'h01 << (c - 3'h1);
  endfunction

  // consecutive samples needed before a flag is set
  function automatic logic [3:0] need_count(input logic [1:0] t);
    case (t)
      2'h1: return 4'h2;
      2'h2: return 4'h4;
      2'h3: return 4'h8;
      default: return 4'h1;
    endcase
  endfunction

endpackage

// ### shared/ostd_cmp_if.sv
// settings and result of one limit instance
// settings driven by the register block, hit driven by the compare unit
`timescale 1ns/100ps
interface ostd_cmp_if;
  logic enable;
  logic [2:0] slot;
  logic chan;
  logic [7:0] upper;
  logic [7:0] lower;
  logic [1:0] time_code;
  logic [2:0] level_code;
  logic hit;

  modport ctl (
    output enable, slot, chan, upper, lower, time_code, level_code,
    input hit
  );
  modport unit (
    input enable, slot, chan, upper, lower, time_code, level_code,
    output hit
  );
endinterface

// ### logic/ostd_limit_unit.sv
// one limit instance: compare, count, one-cycle hit pulse
// sample bus comes from same-clock logic, no synchroniser
`timescale 1ns/100ps
module ostd_limit_unit
  import ostd_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // sample stream
  input wire logic smp_valid,
  input wire logic [2:0] smp_slot,
  input wire logic smp_chan,
  input wire logic [CODE_W-1:0] smp_code,
  // settings and result
  ostd_cmp_if.unit cfg
);

  logic [CODE_W:0] up_lim;
  logic [CODE_W:0] lo_lim;
  logic [CODE_W:0] half;
  logic [CODE_W:0] code_x;
  logic above;
  logic below;
  logic watch;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] cnt_inc;
  logic hit_q;
  logic hit_d;

  ////////////////////////////////////////////////////////////////////////
  // compare and count
  always_comb begin
    up_lim = limit_code(cfg.upper);
    lo_lim = limit_code(cfg.lower);
    half = {13'h0000, half_band(cfg.level_code)};
    code_x = {1'b0, smp_code};
    // band pushes each trip point outward by half
    above = (cfg.upper != 8'h00) && (code_x > up_lim + half);
    // sum on the sample side avoids underflow
    below = (cfg.lower != 8'h00) && (code_x + half < lo_lim);
    watch = smp_valid && (smp_slot == cfg.slot)
      && (smp_chan == cfg.chan);
    cnt_inc = cnt_q + 4'h1;
    cnt_d = cnt_q;
    hit_d = 1'b0;
    if (!cfg.enable) begin
      cnt_d = 4'h0;
    end else if (watch) begin
      if (above || below) begin
        if (cnt_q != CNT_MAX) begin
          cnt_d = cnt_inc;
        end
        hit_d = (cnt_inc >= need_count(cfg.time_code));
      end else begin
        cnt_d = 4'h0;
      end
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      hit_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end

  assign cfg.hit = hit_q;

endmodule // ostd_limit_unit

// ### logic/ostd_top.sv
// dual optical limit detector with APB register access
// apb and sample stream are on pclk; interrupt pin is active low
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module ostd_top
  import ostd_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  // converted samples from the sequencer
  input wire logic sample_valid,
  input wire logic [2:0] sample_slot,
  input wire logic sample_chan,
  input wire logic [CODE_W-1:0] sample_code,
  // interrupt pin
  output logic interrupt_out_n
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // configuration registers
  logic [7:0] src_q;
  logic [7:0] src_d;
  logic [7:0] hyst_q;
  logic [7:0] hyst_d;
  logic [7:0] up1_q;
  logic [7:0] up1_d;
  logic [7:0] lo1_q;
  logic [7:0] lo1_d;
  logic [7:0] up2_q;
  logic [7:0] up2_d;
  logic [7:0] lo2_q;
  logic [7:0] lo2_d;

  // status and interrupt
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] irq_en_q;
  logic [7:0] irq_en_d;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic irq_n_q;
  logic irq_n_d;

  // bus side
  ostd_apb_state_type state_q;
  ostd_apb_state_type state_d;
  logic pready_q;
  logic pready_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  // address decode
  logic [7:0] idx;
  logic aligned;
  logic mapped;
  logic [7:0] rd_val;
  logic commit;
  logic wr;
  logic [7:0] wbyte;

  // one carrier per instance
  ostd_cmp_if th1 ();
  ostd_cmp_if th2 ();

  ////////////////////////////////////////////////////////////////////////
  // instance settings

  // first instance sits in the low nibble of the source word
  assign th1.enable = sel_on(src_q[SRC1_LSB +: 3]);
  assign th1.slot = src_q[SRC1_LSB +: 3];
  assign th1.chan = hyst_q[CHAN1_BIT];
  assign th1.upper = up1_q;
  assign th1.lower = lo1_q;
  assign th1.time_code = hyst_q[TIME_LSB +: 2];
  assign th1.level_code = hyst_q[LEVEL_LSB +: 3];

  // second instance shares the same count and band fields
  assign th2.enable = sel_on(src_q[SRC2_LSB +: 3]);
  assign th2.slot = src_q[SRC2_LSB +: 3];
  assign th2.chan = hyst_q[CHAN2_BIT];
  assign th2.upper = up2_q;
  assign th2.lower = lo2_q;
  assign th2.time_code = hyst_q[TIME_LSB +: 2];
  assign th2.level_code = hyst_q[LEVEL_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////
  // compare units

  ostd_limit_unit u_first (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .smp_valid(sample_valid),
    .smp_slot(sample_slot),
    .smp_chan(sample_chan),
    .smp_code(sample_code),
    .cfg(th1)
  );

  ostd_limit_unit u_second (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .smp_valid(sample_valid),
    .smp_slot(sample_slot),
    .smp_chan(sample_chan),
    .smp_code(sample_code),
    .cfg(th2)
  );

  ////////////////////////////////////////////////////////////////////////
  // address decode and read mux

  // only word aligned addresses of the 8-bit index space decode
  always_comb begin
    idx = paddr[9:2];
    aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == 2'b00);
    mapped = 1'b1;
    rd_val = 8'h00;
    case (idx)
      IDX_STATUS: rd_val = status_q;
      IDX_SRC: rd_val = src_q;
      IDX_HYST: rd_val = hyst_q;
      IDX_UP1: rd_val = up1_q;
      IDX_LO1: rd_val = lo1_q;
      IDX_UP2: rd_val = up2_q;
      IDX_LO2: rd_val = lo2_q;
      IDX_IRQ_EN: rd_val = irq_en_q;
      default: mapped = 1'b0;
    endcase
    if (!aligned) begin
      mapped = 1'b0;
      rd_val = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb handshake

  // one wait state: ready rises one edge into the access phase,
  // which keeps read data and the error flag on flops
  always_comb begin
    state_d = state_q;
    pready_d = 1'b0;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    case (state_q)
      OSTD_APB_IDLE: begin
        if (psel && penable) begin
          state_d = OSTD_APB_ACK;
          pready_d = 1'b1;
          pslverr_d = !mapped;
          prdata_d = pwrite ? '0 : {24'h000000, rd_val};
        end
      end
      OSTD_APB_ACK: begin
        state_d = OSTD_APB_IDLE;
      end
      default: begin
        state_d = OSTD_APB_IDLE;
      end
    endcase
  end

  // the write lands on the same edge the master sees ready
  assign commit = psel && penable && pready_q;
  assign wr = commit && pwrite && mapped;
  assign wbyte = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // register writes

  // reserved bits are masked so they always read zero
  always_comb begin
    src_d = src_q;
    hyst_d = hyst_q;
    up1_d = up1_q;
    lo1_d = lo1_q;
    up2_d = up2_q;
    lo2_d = lo2_q;
    irq_en_d = irq_en_q;
    if (wr) begin
      case (idx)
        IDX_SRC: src_d = wbyte & SRC_MASK;
        IDX_HYST: hyst_d = wbyte & HYST_MASK;
        IDX_UP1: up1_d = wbyte;
        IDX_LO1: lo1_d = wbyte;
        IDX_UP2: up2_d = wbyte;
        IDX_LO2: lo2_d = wbyte;
        IDX_IRQ_EN: irq_en_d = wbyte & FLAG_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky flags and interrupt pin

  // a hit in the clearing cycle survives: set wins over clear
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLAG1_BIT] = th1.hit;
    flag_set[FLAG2_BIT] = th2.hit;
    flag_clr = 8'h00;
    if (wr && (idx == IDX_STATUS)) begin
      flag_clr = wbyte & FLAG_MASK;
    end
    status_d = ((status_q & ~flag_clr) | flag_set) & FLAG_MASK;
    // next values feed the pin so it tracks with no extra lag
    irq_n_d = !(|(status_d & irq_en_d));
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // configuration words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= RST_SRC;
      hyst_q <= RST_HYST;
      up1_q <= RST_UP;
      lo1_q <= RST_LO;
      up2_q <= RST_UP;
      lo2_q <= RST_LO;
      irq_en_q <= RST_IRQ_EN;
    end else if (ce) begin
      src_q <= src_d;
      hyst_q <= hyst_d;
      up1_q <= up1_d;
      lo1_q <= lo1_d;
      up2_q <= up2_d;
      lo2_q <= lo2_d;
      irq_en_q <= irq_en_d;
    end
  end

  // status and pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= RST_STATUS;
      irq_n_q <= 1'b1;
    end else if (ce) begin
      status_q <= status_d;
      irq_n_q <= irq_n_d;
    end
  end

  // bus answer; ce also stalls the bus, so keep it high
  // while software is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= OSTD_APB_IDLE;
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign interrupt_out_n = irq_n_q;

endmodule // ostd_top

// ### sim/ostd_sva.sv
// port-level checker for the dual optical limit detector
// sees only ostd_top ports; shadow registers freeze with ce
`timescale 1ns/100ps
module ostd_sva
  import ostd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pslverr,
  // samples and pin
  input wire logic sample_valid,
  input wire logic [2:0] sample_slot,
  input wire logic sample_chan,
  input wire logic [CODE_W-1:0] sample_code,
  input wire logic interrupt_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic on_any;
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [7:0] src_q;
  logic [7:0] src_d;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of committed writes, since the pin depends on them
  assign wr = psel & penable & pready & pwrite;
  always_comb begin
    en_d = en_q;
    src_d = src_q;
    if (wr && paddr == 12'h160) en_d = pwdata[7:0] & FLAG_MASK;
    if (wr && paddr == 12'h140) src_d = pwdata[7:0] & SRC_MASK;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= RST_IRQ_EN;
      src_q <= RST_SRC;
    end else if (ce) begin
      en_q <= en_d;
      src_q <= src_d;
    end
  end
  // codes 0 and 7 both mean off
  assign on_any = (src_q[2:0] != 3'h0 && src_q[2:0] != 3'h7) ||
    (src_q[6:4] != 3'h0 && src_q[6:4] != 3'h7);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_quiet;
    (!on_any && !wr) [*3];
  endsequence
  property p_wait_state;
    s_setup |-> !pready ##1 pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_high_zero;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  property p_err_data;
    pready && pslverr && !pwrite |-> prdata == 32'h00000000;
  endproperty
  property p_fall_cause;
    $fell(interrupt_out_n) |-> $past(sample_valid, 2) || $past(wr) ||
      $past(wr, 2);
  endproperty
  property p_rise_cause;
    $rose(interrupt_out_n) |-> $past(wr) || $past(wr, 2);
  endproperty
  property p_masked_quiet;
    en_q == 8'h00 && !wr |=> interrupt_out_n;
  endproperty
  property p_off_quiet;
    s_quiet |=> !$fell(interrupt_out_n);
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  a_high_zero: assert property (p_high_zero)
    else $error("read data upper bits not zero");
  a_err_data: assert property (p_err_data)
    else $error("refused read returned data");
  a_fall_cause: assert property (p_fall_cause)
    else $error("pin fell without sample or write");
  a_rise_cause: assert property (p_rise_cause)
    else $error("pin rose without a write");
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("pin low while all enables clear");
  a_off_quiet: assert property (p_off_quiet)
    else $error("pin fell with both instances off");
endmodule // ostd_sva

// ### sim/testbench.sv
// self-checking bench for the dual optical limit detector
// drives apb and the sample stream itself; ce dropped once, bus idle
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench
  import ostd_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, ce, psel, penable, pwrite, pready, pslverr, rerr;
  logic sample_valid, sample_chan, interrupt_out_n;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdat;
  logic [2:0] sample_slot;
  logic [CODE_W-1:0] sample_code;
  logic [7:0] en_v;
  int fail_count = 0;
  int checks = 0;
  logic [11:0] ra [8] = '{12'h000, 12'h140, 12'h144, 12'h148, 12'h14C,
    12'h150, 12'h154, 12'h160};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
  logic [11:0] ma [4] = '{12'h140, 12'h144, 12'h160, 12'h000};
  logic [7:0] mv [4] = '{8'h77, 8'hDF, 8'h06, 8'h00};
  ostd_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_slot(sample_slot),
    .sample_chan(sample_chan), .sample_code(sample_code),
    .interrupt_out_n(interrupt_out_n));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 pclk = ~pclk;
  end
  // one transfer, then an idle cycle so strobes never double-assign
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    `CHK("pready", 1'b1, pready)
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK($sformatf("reg %h", a), {24'h000000, e}, rdat)
  endtask
  task automatic smp(input logic [2:0] s, input logic c,
      input logic [19:0] v);
    sample_valid <= 1'b1;
    sample_slot <= s;
    sample_chan <= c;
    sample_code <= v;
    @(posedge pclk);
  endtask
  // let flags land, check pin and status, then clear them
  task automatic flags(input logic [1:0] e);
    sample_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("pin", ~|(e & en_v[2:1]), interrupt_out_n)
    rd(12'h000, {5'h00, e, 1'b0});
    wr(12'h000, 8'h06);
  endtask
  task automatic complete_run;
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    fail_count++;
    complete_run();
  end
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sample_valid = 1'b0;
    sample_slot = 3'h0;
    sample_chan = 1'b0;
    sample_code = '0;
    en_v = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, then writable masks
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    for (int i = 0; i < 4; i++) begin
      wr(ma[i], 8'hFF);
      rd(ma[i], mv[i]);
    end
    // unmapped and misaligned accesses are refused
    apb(1'b0, 12'h15C, 32'h00000000);
    `CHK("err", 1'b1, rerr)
    `CHK("data", 32'h00000000, rdat)
    apb(1'b1, 12'h141, 32'h00000011);
    `CHK("err", 1'b1, rerr)
    // upper address bits set: outside the index space
    apb(1'b0, 12'h540, 32'h00000000);
    `CHK("err", 1'b1, rerr)
    `CHK("data", 32'h00000000, rdat)
    rd(12'h140, 8'h77);
    // inst1 slot 3 chan one, inst2 slot 5 chan two, limit 2048
    wr(12'h148, 8'h01);
    wr(12'h150, 8'h01);
    wr(12'h140, 8'h53);
    wr(12'h144, 8'h80);
    en_v = 8'h06;
    smp(3'h3, 1'b0, 20'h00800);
    flags(2'b00);
    smp(3'h3, 1'b0, 20'h00801);
    flags(2'b01);
    smp(3'h5, 1'b1, 20'h00801);
    flags(2'b10);
    smp(3'h4, 1'b0, 20'h00FA0);
    smp(3'h3, 1'b1, 20'h00FA0);
    smp(3'h5, 1'b0, 20'h00FA0);
    flags(2'b00);
    // a sample seen while ce is low must leave no trace
    ce <= 1'b0;
    smp(3'h3, 1'b0, 20'h00FA0);
    ce <= 1'b1;
    flags(2'b00);
    wr(12'h160, 8'h04);
    en_v = 8'h04;
    smp(3'h3, 1'b0, 20'h00FA0);
    flags(2'b01);
    wr(12'h160, 8'h06);
    en_v = 8'h06;
    wr(12'h140, 8'h07);
    smp(3'h3, 1'b0, 20'h00FA0);
    smp(3'h7, 1'b0, 20'h00FA0);
    smp(3'h0, 1'b1, 20'h00FA0);
    smp(3'h5, 1'b1, 20'h00FA0);
    flags(2'b00);
    wr(12'h140, 8'h53);
    // count codes: an in-limit sample restarts the run
    for (int t = 1; t < 4; t++) begin
      wr(12'h144, 8'h80 | 8'(t << 3));
      for (int r = 0; r < 2; r++) begin
        smp(3'h3, 1'b0, 20'h00064);
        smp(3'h5, 1'b1, 20'h00064);
        for (int k = 1; k < (1 << t); k++) begin
          smp(3'h3, 1'b0, 20'h00FA0);
          smp(3'h5, 1'b1, 20'h00FA0);
        end
      end
      flags(2'b00);
      smp(3'h3, 1'b0, 20'h00FA0);
      smp(3'h5, 1'b1, 20'h00FA0);
      flags(2'b11);
    end
    // band codes: inst1 upper side, inst2 lower at 4096, upper at top
    wr(12'h150, 8'hFF);
    wr(12'h154, 8'h02);
    for (int c = 1; c < 8; c++) begin
      wr(12'h144, 8'h80 | 8'(c));
      smp(3'h3, 1'b0, 20'h00800 + 20'(1 << (c - 1)));
      smp(3'h5, 1'b1, 20'h01000 - 20'(1 << (c - 1)));
      smp(3'h3, 1'b0, 20'h00000);
      smp(3'h5, 1'b1, 20'h7F800 + 20'(1 << (c - 1)));
      flags(2'b00);
      smp(3'h3, 1'b0, 20'h00801 + 20'(1 << (c - 1)));
      smp(3'h5, 1'b1, 20'h00FFF - 20'(1 << (c - 1)));
      flags(2'b11);
    end
    complete_run();
  end
endmodule // testbench
bind ostd_top ostd_sva u_sva (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sample_valid(sample_valid), .sample_slot(sample_slot),
  .sample_chan(sample_chan), .sample_code(sample_code),
  .interrupt_out_n(interrupt_out_n));
